// [verilog/pmgr_pkg.sv]
package pmgr_pkg;

  // printed offsets are register indices; byte address is index * 4
  localparam logic [23:0] CTRL_IDX = 24'hfffc60;
  localparam logic [23:0] STAT_IDX = 24'hfffc62;
  localparam logic [23:0] CRC_IDX = 24'hfffc40;
  localparam logic [31:0] CTRL_ADDR = {6'h00, CTRL_IDX, 2'h0};
  localparam logic [31:0] STAT_ADDR = {6'h00, STAT_IDX, 2'h0};
  localparam logic [31:0] CRC_ADDR = {6'h00, CRC_IDX, 2'h0};

  // power_mode_control fields
  localparam int PSM_BIT = 0;
  localparam int IDLE_BIT = 1;
  localparam int HALT_BIT = 2;
  localparam int WBPSM_BIT = 3;
  localparam int MAIN_OSC_DISABLE_BIT = 4;
  localparam int PLL_DISABLE_LOWPOWER_BIT = 5;
  localparam int OSC_GATE_ON_SLEEP_BIT = 6;
  localparam int PLL_GATE_ON_SLEEP_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // clock_reset_control fields
  localparam int SLOW_SEL_BIT = 0;
  localparam int FAST_SEL_BIT = 1;
  localparam int PLL_POWER_DOWN_BIT = 2;
  localparam int AUX1_EN_BIT = 3;
  localparam int AUX2_EN_BIT = 4;
  localparam logic [7:0] CRC_RST = 8'h06;

  // power_mode_status fields
  localparam int LOW_OSC_STABLE_BIT = 0;
  localparam int MAIN_OSC_STABLE_BIT = 1;
  localparam int PLL_STABLE_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_PSAVE = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_HALT = 3'b011,
    MODE_WAKE = 3'b100
  } pmgr_mode_t;

  typedef enum logic [1:0] {
    SYS_MAIN = 2'b00,
    SYS_PLL = 2'b01,
    SYS_SLOW = 2'b10,
    SYS_NONE = 2'b11
  } pmgr_sys_src_t;

  typedef struct packed {
    logic main_osc_en;
    logic pll_en;
    pmgr_sys_src_t sys_src;
    logic slow_run;
    logic slow_from_low_osc;
    logic timer_clk_en;
    logic aux1_en;
    logic aux2_en;
    logic link_on_aux1;
  } pmgr_clk_t;

  localparam pmgr_clk_t CLK_RST = '{
    main_osc_en: 1'b1, pll_en: 1'b0, sys_src: SYS_MAIN, slow_run: 1'b1,
    slow_from_low_osc: 1'b0, timer_clk_en: 1'b1, aux1_en: 1'b0, aux2_en: 1'b0,
    link_on_aux1: 1'b0};

endpackage : pmgr_pkg

// [verilog/pmgr_power_mode_manager.sv]
`timescale 1ns/1ns
// Summary of operation
// - four modes: active, power save, idle, halt, each with own clocking
// - any reset leaves the device in active mode
// - active: main oscillator runs, timer/watchdog on slow clock
// - active: system clock from pll or main clock; pll may be off
// - wait stalls the cpu until an interrupt arrives
// - slow clock from low oscillator or divided main clock
// - low-frequency oscillator runs in every mode
// - power save: slow clock is the system clock
// - auxiliary clocks run in low power only while main clock runs
// - link controller runs on low clock or auxiliary clock 1
// - idle: system clock stopped, manager and timer stay on slow clock
// - halt: all clocks stopped, oscillator and pll off
// - halt: timer counters stop, all state retained
// - link controller sleep is reported to the gating logic
// - low power and link asleep: gating bits stop oscillator and pll
// - disable bits stop oscillator/pll in low power, over gating
// - active and halt ignore disable and gating bits
// - pll power-down stops pll in every mode, not the oscillator
// - control at index fffc60, status at index fffc62
// - reset clears every power_mode_control bit; clock_reset_control resets to 06
// - no low-power entry while low oscillator is unstable
module pmgr_power_mode_manager (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic wait_exec_i,
  input wire logic wakeup_i,
  input wire logic low_osc_stable_i,
  input wire logic main_osc_stable_i,
  input wire logic pll_stable_i,
  input wire logic link_sleep_i,
  output logic cpu_stall_o,
  output pmgr_pkg::pmgr_mode_t mode_o,
  output pmgr_pkg::pmgr_clk_t clk_ctl_o
);

  // write channel holding
  logic aw_full;
  logic w_full;
  logic [31:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic next_aw_full;
  logic next_w_full;
  logic next_rvalid;

  // control state
  logic wbpsm;
  logic main_osc_disable;
  logic pll_disable_lowpower;
  logic osc_gate_on_sleep;
  logic pll_gate_on_sleep;
  logic req_psm;
  logic req_idle;
  logic req_halt;
  logic slow_sel;
  logic fast_sel;
  logic pll_power_down;
  logic aux1_en;
  logic aux2_en;
  pmgr_pkg::pmgr_mode_t next_mode;
  pmgr_pkg::pmgr_clk_t next_clk;

  // bus decode
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire do_wr = aw_full & w_full & ~s_axi_bvalid_o;
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire wr_ctrl = aw_addr == pmgr_pkg::CTRL_ADDR;
  wire wr_stat = aw_addr == pmgr_pkg::STAT_ADDR;
  wire wr_crc = aw_addr == pmgr_pkg::CRC_ADDR;
  wire wr_hit = wr_ctrl | wr_stat | wr_crc;
  wire rd_ctrl = s_axi_araddr_i == pmgr_pkg::CTRL_ADDR;
  wire rd_stat = s_axi_araddr_i == pmgr_pkg::STAT_ADDR;
  wire rd_crc = s_axi_araddr_i == pmgr_pkg::CRC_ADDR;
  wire rd_hit = rd_ctrl | rd_stat | rd_crc;
  wire ctrl_we = do_wr & wr_ctrl & w_lane;
  wire crc_we = do_wr & wr_crc & w_lane;

  // mode views
  wire in_active = mode_o == pmgr_pkg::MODE_ACTIVE;
  wire in_psave = mode_o == pmgr_pkg::MODE_PSAVE;
  wire in_idle = mode_o == pmgr_pkg::MODE_IDLE;
  wire in_halt = mode_o == pmgr_pkg::MODE_HALT;
  wire lowpwr = in_psave | in_idle;
  wire entering_active = next_mode == pmgr_pkg::MODE_ACTIVE & ~in_active;

  // software leaving a low-power mode by clearing its bit
  wire psm_clr = ctrl_we & in_psave & ~w_byte[pmgr_pkg::PSM_BIT];
  wire idle_clr = ctrl_we & in_idle & ~w_byte[pmgr_pkg::IDLE_BIT];

  // entry needs a stable low oscillator
  wire lp_ok = low_osc_stable_i & ~wakeup_i;
  wire go_halt = lp_ok & req_halt & wbpsm & wait_exec_i;
  wire go_idle = lp_ok & req_idle & wbpsm & wait_exec_i;
  // without wbpsm power save starts at once
  wire go_psave = lp_ok & req_psm & (~wbpsm | wait_exec_i);
  // pll counts as ready when it is held off
  wire pll_ok = pll_stable_i | pll_power_down;

  // disable bits dominate, gating only adds
  wire osc_off_lp = main_osc_disable | (osc_gate_on_sleep & link_sleep_i);
  wire pll_off_lp = pll_disable_lowpower | (pll_gate_on_sleep & link_sleep_i);

  wire [7:0] ctrl_rd = {
    pll_gate_on_sleep, osc_gate_on_sleep, pll_disable_lowpower,
    main_osc_disable, wbpsm, in_halt, in_idle, in_psave};
  wire [7:0] stat_rd = {5'h00, pll_stable_i | ~clk_ctl_o.pll_en,
    main_osc_stable_i, low_osc_stable_i};
  wire [7:0] crc_rd = {3'h0, aux2_en, aux1_en, pll_power_down, fast_sel,
    slow_sel};
  wire [7:0] rd_byte = rd_ctrl ? ctrl_rd : rd_stat ? stat_rd : rd_crc ? crc_rd : 8'h00;

  assign next_aw_full = (aw_full & ~do_wr) | aw_take;
  assign next_w_full = (w_full & ~do_wr) | w_take;
  assign next_rvalid = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

  // address and data are taken in either order, one write in flight
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready_o <= ~next_aw_full;
      s_axi_wready_o <= ~next_w_full;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_byte <= s_axi_wdata_i[7:0];
        w_lane <= s_axi_wstrb_i[0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= pmgr_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? pmgr_pkg::RESP_OKAY : pmgr_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= pmgr_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid_o <= next_rvalid;
      s_axi_arready_o <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata_o <= {24'h00_0000, rd_byte};
        s_axi_rresp_o <= rd_hit ? pmgr_pkg::RESP_OKAY : pmgr_pkg::RESP_SLVERR;
      end
    end
  end

  // control register; wakeup clears after the software write
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wbpsm <= pmgr_pkg::CTRL_RST[pmgr_pkg::WBPSM_BIT];
      main_osc_disable <= pmgr_pkg::CTRL_RST[pmgr_pkg::MAIN_OSC_DISABLE_BIT];
      pll_disable_lowpower <= pmgr_pkg::CTRL_RST[pmgr_pkg::PLL_DISABLE_LOWPOWER_BIT];
      osc_gate_on_sleep <= pmgr_pkg::CTRL_RST[pmgr_pkg::OSC_GATE_ON_SLEEP_BIT];
      pll_gate_on_sleep <= pmgr_pkg::CTRL_RST[pmgr_pkg::PLL_GATE_ON_SLEEP_BIT];
      req_psm <= pmgr_pkg::CTRL_RST[pmgr_pkg::PSM_BIT];
      req_idle <= pmgr_pkg::CTRL_RST[pmgr_pkg::IDLE_BIT];
      req_halt <= pmgr_pkg::CTRL_RST[pmgr_pkg::HALT_BIT];
    end else begin
      if (ctrl_we) begin
        wbpsm <= w_byte[pmgr_pkg::WBPSM_BIT];
        main_osc_disable <= w_byte[pmgr_pkg::MAIN_OSC_DISABLE_BIT];
        pll_disable_lowpower <= w_byte[pmgr_pkg::PLL_DISABLE_LOWPOWER_BIT];
        osc_gate_on_sleep <= w_byte[pmgr_pkg::OSC_GATE_ON_SLEEP_BIT];
        pll_gate_on_sleep <= w_byte[pmgr_pkg::PLL_GATE_ON_SLEEP_BIT];
        req_psm <= w_byte[pmgr_pkg::PSM_BIT] & ~in_psave;
        req_idle <= w_byte[pmgr_pkg::IDLE_BIT] & ~in_idle;
        req_halt <= w_byte[pmgr_pkg::HALT_BIT];
      end
      // a request is spent once its mode is reached
      if (next_mode == pmgr_pkg::MODE_PSAVE) begin
        req_psm <= 1'b0;
      end
      if (next_mode == pmgr_pkg::MODE_IDLE) begin
        req_idle <= 1'b0;
        req_psm <= 1'b0;
      end
      if (next_mode == pmgr_pkg::MODE_HALT) begin
        req_halt <= 1'b0;
        req_idle <= 1'b0;
        req_psm <= 1'b0;
      end
      if (wakeup_i) begin
        main_osc_disable <= 1'b0;
        pll_disable_lowpower <= 1'b0;
        req_psm <= 1'b0;
        req_idle <= 1'b0;
        req_halt <= 1'b0;
      end
      if (entering_active) begin
        osc_gate_on_sleep <= 1'b0;
        pll_gate_on_sleep <= 1'b0;
      end
    end
  end

  // clock source register; unsafe pll requests are ignored
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      slow_sel <= pmgr_pkg::CRC_RST[pmgr_pkg::SLOW_SEL_BIT];
      fast_sel <= pmgr_pkg::CRC_RST[pmgr_pkg::FAST_SEL_BIT];
      pll_power_down <= pmgr_pkg::CRC_RST[pmgr_pkg::PLL_POWER_DOWN_BIT];
      aux1_en <= pmgr_pkg::CRC_RST[pmgr_pkg::AUX1_EN_BIT];
      aux2_en <= pmgr_pkg::CRC_RST[pmgr_pkg::AUX2_EN_BIT];
    end else if (crc_we) begin
      slow_sel <= w_byte[pmgr_pkg::SLOW_SEL_BIT];
      aux1_en <= w_byte[pmgr_pkg::AUX1_EN_BIT];
      aux2_en <= w_byte[pmgr_pkg::AUX2_EN_BIT];
      // pll only when powered and stable
      if (w_byte[pmgr_pkg::FAST_SEL_BIT] | (~pll_power_down & pll_stable_i)) begin
        fast_sel <= w_byte[pmgr_pkg::FAST_SEL_BIT];
      end
      if (~w_byte[pmgr_pkg::PLL_POWER_DOWN_BIT] | fast_sel) begin
        pll_power_down <= w_byte[pmgr_pkg::PLL_POWER_DOWN_BIT];
      end
    end
  end

  always_comb begin
    next_mode = mode_o;
    case (mode_o)
      pmgr_pkg::MODE_ACTIVE: begin
        if (go_halt) begin
          next_mode = pmgr_pkg::MODE_HALT;
        end else if (go_idle) begin
          next_mode = pmgr_pkg::MODE_IDLE;
        end else if (go_psave) begin
          next_mode = pmgr_pkg::MODE_PSAVE;
        end
      end
      pmgr_pkg::MODE_PSAVE: begin
        if (wakeup_i | psm_clr) begin
          next_mode = pmgr_pkg::MODE_WAKE;
        end else if (go_halt) begin
          next_mode = pmgr_pkg::MODE_HALT;
        end else if (go_idle) begin
          next_mode = pmgr_pkg::MODE_IDLE;
        end
      end
      pmgr_pkg::MODE_IDLE: begin
        if (wakeup_i | idle_clr) begin
          next_mode = pmgr_pkg::MODE_WAKE;
        end
      end
      pmgr_pkg::MODE_HALT: begin
        if (wakeup_i) begin
          next_mode = pmgr_pkg::MODE_WAKE;
        end
      end
      pmgr_pkg::MODE_WAKE: begin
        // active only with a stable main clock and a stable or powered-down pll
        if (main_osc_stable_i & pll_ok) begin
          next_mode = pmgr_pkg::MODE_ACTIVE;
        end
      end
      default: begin
        next_mode = pmgr_pkg::MODE_ACTIVE;
      end
    endcase
  end

  // clock controls from mode, disables and link sleep
  always_comb begin
    next_clk = pmgr_pkg::CLK_RST;
    // active and halt override the low-power controls
    next_clk.main_osc_en = ~in_halt & ~(lowpwr & osc_off_lp);
    next_clk.pll_en = ~pll_power_down & ~in_halt & ~(lowpwr & pll_off_lp);
    case (mode_o)
      pmgr_pkg::MODE_ACTIVE: begin
        next_clk.sys_src = fast_sel ? pmgr_pkg::SYS_MAIN : pmgr_pkg::SYS_PLL;
      end
      pmgr_pkg::MODE_PSAVE: begin
        next_clk.sys_src = pmgr_pkg::SYS_SLOW;
      end
      pmgr_pkg::MODE_IDLE: begin
        next_clk.sys_src = pmgr_pkg::SYS_NONE;
      end
      pmgr_pkg::MODE_HALT: begin
        next_clk.sys_src = pmgr_pkg::SYS_NONE;
      end
      default: begin
        next_clk.sys_src = pmgr_pkg::SYS_NONE;
      end
    endcase
    // slow clock and timer stop in halt
    next_clk.slow_run = ~in_halt;
    next_clk.timer_clk_en = ~in_halt;
    // low oscillator is never switched off here
    next_clk.slow_from_low_osc = slow_sel;
    next_clk.aux1_en = aux1_en & next_clk.main_osc_en & main_osc_stable_i;
    next_clk.aux2_en = aux2_en & next_clk.main_osc_en & main_osc_stable_i;
    // link falls back to the low clock
    next_clk.link_on_aux1 = next_clk.aux1_en;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_o <= pmgr_pkg::MODE_ACTIVE;
      clk_ctl_o <= pmgr_pkg::CLK_RST;
      cpu_stall_o <= 1'b0;
    end else begin
      mode_o <= next_mode;
      clk_ctl_o <= next_clk;
      if (wakeup_i) begin
        cpu_stall_o <= 1'b0;
      end else if (wait_exec_i) begin
        cpu_stall_o <= 1'b1;
      end
    end
  end

endmodule : pmgr_power_mode_manager

// [verification/pmgr_props.sv]
`timescale 1ns/1ns
module pmgr_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wait_exec_i,
  input wire logic wakeup_i,
  input wire logic low_osc_stable_i,
  input wire logic cpu_stall_o,
  input pmgr_pkg::pmgr_mode_t mode_o,
  input pmgr_pkg::pmgr_clk_t clk_ctl_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_rst;
    $rose(rst_b_i) |-> mode_o == pmgr_pkg::MODE_ACTIVE && clk_ctl_o == pmgr_pkg::CLK_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_act;
    mode_o == pmgr_pkg::MODE_ACTIVE ##1 mode_o == pmgr_pkg::MODE_ACTIVE |-> clk_ctl_o.main_osc_en &&
      clk_ctl_o.timer_clk_en && clk_ctl_o.sys_src inside {pmgr_pkg::SYS_MAIN, pmgr_pkg::SYS_PLL};
  endproperty
  a_act: assert property (p_act) else $error("active clocking wrong");
  property p_psave;
    mode_o == pmgr_pkg::MODE_PSAVE [*2] |-> clk_ctl_o.sys_src == pmgr_pkg::SYS_SLOW && clk_ctl_o.timer_clk_en;
  endproperty
  a_psave: assert property (p_psave) else $error("power save clocking wrong");
  property p_idle;
    mode_o == pmgr_pkg::MODE_IDLE [*2] |-> clk_ctl_o.sys_src == pmgr_pkg::SYS_NONE && clk_ctl_o.timer_clk_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clocking wrong");
  property p_halt;
    mode_o == pmgr_pkg::MODE_HALT [*2] |-> !clk_ctl_o.main_osc_en && !clk_ctl_o.pll_en &&
      clk_ctl_o.sys_src == pmgr_pkg::SYS_NONE && !clk_ctl_o.slow_run && !clk_ctl_o.timer_clk_en;
  endproperty
  a_halt: assert property (p_halt) else $error("halt clocking wrong");
  property p_lock;
    mode_o == pmgr_pkg::MODE_ACTIVE && !low_osc_stable_i |=> mode_o == pmgr_pkg::MODE_ACTIVE;
  endproperty
  a_lock: assert property (p_lock) else $error("left active on unstable low osc");
  property p_stall;
    $rose(cpu_stall_o) |-> $past(wait_exec_i);
  endproperty
  a_stall: assert property (p_stall) else $error("stall without wait");
  property p_wake;
    wakeup_i |=> !cpu_stall_o;
  endproperty
  a_wake: assert property (p_wake) else $error("stall kept after wakeup");
  c_psave: cover property (mode_o == pmgr_pkg::MODE_PSAVE);
  c_idle: cover property (mode_o == pmgr_pkg::MODE_IDLE);
  c_halt: cover property (mode_o == pmgr_pkg::MODE_HALT);
endmodule : pmgr_props

bind pmgr_power_mode_manager pmgr_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .wait_exec_i(wait_exec_i),
  .wakeup_i(wakeup_i), .low_osc_stable_i(low_osc_stable_i), .cpu_stall_o(cpu_stall_o), .mode_o(mode_o),
  .clk_ctl_o(clk_ctl_o));

// [verification/pmgr_osc_model.sv]
`timescale 1ns/1ns
module pmgr_osc_model #(
  parameter int LOW_DLY = 60,
  parameter int MAIN_DLY = 8,
  parameter int PLL_DLY = 12
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic main_osc_en_i,
  input wire logic pll_en_i,
  output logic low_osc_stable_o,
  output logic main_osc_stable_o,
  output logic pll_stable_o
);
  int low_n = 0, main_n = 0, pll_n = 0;
  always @(posedge clk_i) begin
    low_n <= !rst_b_i ? 0 : (low_n < LOW_DLY) ? low_n + 1 : low_n;
    main_n <= !main_osc_en_i ? 0 : (main_n < MAIN_DLY) ? main_n + 1 : main_n;
    // pll needs its reference, so it loses lock with the main oscillator
    pll_n <= !(pll_en_i && main_osc_en_i) ? 0 : (pll_n < PLL_DLY) ? pll_n + 1 : pll_n;
  end
  assign low_osc_stable_o = (low_n == LOW_DLY);
  assign main_osc_stable_o = (main_n == MAIN_DLY);
  assign pll_stable_o = (pll_n == PLL_DLY);
endmodule : pmgr_osc_model

// [verification/pmgr_power_mode_manager_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end
module pmgr_power_mode_manager_tb;
  localparam logic [31:0] CA = pmgr_pkg::CTRL_ADDR;
  localparam logic [31:0] KA = pmgr_pkg::CRC_ADDR;
  localparam logic [1:0] OK = pmgr_pkg::RESP_OKAY;
  localparam logic [1:0] SE = pmgr_pkg::RESP_SLVERR;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rdy = 1'b0;
  logic wait_exec = 1'b0, wakeup = 1'b0, link_sleep = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, stall, low_st, main_st, pll_st;
  logic [1:0] bresp, rresp;
  pmgr_pkg::pmgr_mode_t mode;
  pmgr_pkg::pmgr_mode_t m_mode = pmgr_pkg::MODE_ACTIVE;
  pmgr_pkg::pmgr_clk_t cc;
  logic [7:0] ctrl_m = 8'h00, crc_m = 8'h06;
  logic [7:0] req [3] = '{8'h0a, 8'h0c, 8'h09};
  pmgr_pkg::pmgr_mode_t tgt [3] = '{pmgr_pkg::MODE_IDLE, pmgr_pkg::MODE_HALT, pmgr_pkg::MODE_PSAVE};
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  logic [8:0] v;
  logic main_st_q = 1'b0;

  always #5 clk_i = ~clk_i;
  // the design sees main stability one edge before the bench looks
  always @(posedge clk_i) main_st_q <= main_st;

  pmgr_power_mode_manager u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(addr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(rdy), .s_axi_araddr_i(addr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rdy),
    .wait_exec_i(wait_exec), .wakeup_i(wakeup), .low_osc_stable_i(low_st), .main_osc_stable_i(main_st),
    .pll_stable_i(pll_st), .link_sleep_i(link_sleep), .cpu_stall_o(stall), .mode_o(mode), .clk_ctl_o(cc));
  pmgr_osc_model u_osc (.clk_i(clk_i), .rst_b_i(rst_b_i), .main_osc_en_i(cc.main_osc_en), .pll_en_i(cc.pll_en),
    .low_osc_stable_o(low_st), .main_osc_stable_o(main_st), .pll_stable_o(pll_st));

  function automatic logic [3:0] exp_clk(input pmgr_pkg::pmgr_mode_t m, input logic [7:0] c, input logic [7:0] k,
    input logic sl);
    logic osc;
    logic pll;
    osc = !(c[4] || (c[6] && sl));
    pll = !k[2] && !(c[5] || (c[7] && sl));
    case (m)
      pmgr_pkg::MODE_ACTIVE: return {1'b1, !k[2], k[1] ? pmgr_pkg::SYS_MAIN : pmgr_pkg::SYS_PLL};
      pmgr_pkg::MODE_PSAVE: return {osc, pll, pmgr_pkg::SYS_SLOW};
      pmgr_pkg::MODE_IDLE: return {osc, pll, pmgr_pkg::SYS_NONE};
      default: return {2'b00, pmgr_pkg::SYS_NONE};
    endcase
  endfunction : exp_clk

  task automatic xfer(input logic rw, input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_i);
    addr <= a;
    wdata <= {24'h0, d};
    arvalid <= rw;
    awvalid <= !rw;
    wvalid <= !rw;
    rdy <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(bvalid || rvalid));
    rdy <= 1'b0;
    if (rw) `CHK(rdata[7:0], d)
    `CHK(rw ? rresp : bresp, er)
  endtask : xfer

  task automatic pulse(input logic w);
    @(posedge clk_i);
    wait_exec <= w;
    wakeup <= !w;
    @(posedge clk_i);
    wait_exec <= 1'b0;
    wakeup <= 1'b0;
  endtask : pulse

  task automatic wait_mode(input pmgr_pkg::pmgr_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    m_mode = m;
    `CHK(mode, m)
  endtask : wait_mode

  task automatic check_clk();
    logic [3:0] e;
    repeat (3) @(posedge clk_i);
    e = exp_clk(m_mode, ctrl_m, crc_m, link_sleep);
    `CHK({cc.main_osc_en, cc.pll_en, cc.sys_src}, e)
    // aux clocks and the link clock need a running, stable main oscillator
    `CHK({cc.aux2_en, cc.aux1_en, cc.link_on_aux1}, {3{e[3] & main_st_q}} & {crc_m[4], crc_m[3], crc_m[3]})
    `CHK({cc.slow_run, cc.timer_clk_en, cc.slow_from_low_osc}, {{2{m_mode != pmgr_pkg::MODE_HALT}}, crc_m[0]})
  endtask : check_clk

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // run should take under a thousand cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    void'($urandom(41));
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    xfer(1, CA, 8'h00, OK);
    xfer(1, KA, 8'h06, OK);
    xfer(1, 32'h40, 8'h00, SE);
    xfer(0, 32'h40, 8'h5a, SE);
    $display("reset test done");
    check_clk();
    // slow clock moved to the low oscillator before the main one may stop; aux clocks on
    crc_m = 8'h1b;
    xfer(0, KA, crc_m, OK);
    check_clk();
    ctrl_m = 8'h01;
    xfer(0, CA, ctrl_m, OK);
    repeat (3) @(posedge clk_i);
    `CHK(mode, pmgr_pkg::MODE_ACTIVE)
    wait_mode(pmgr_pkg::MODE_PSAVE);
    check_clk();
    for (int i = 0; i < 8; i++) begin
      v = 9'($urandom());
      link_sleep <= v[8];
      ctrl_m = {v[7:4], 4'h1};
      xfer(0, CA, ctrl_m, OK);
      check_clk();
      xfer(1, CA, ctrl_m, OK);
    end
    pulse(1'b0);
    wait_mode(pmgr_pkg::MODE_ACTIVE);
    ctrl_m = 8'h00;
    xfer(1, CA, ctrl_m, OK);
    ctrl_m = 8'hf0;
    link_sleep <= 1'b1;
    xfer(0, CA, ctrl_m, OK);
    check_clk();
    $display("gating test done");
    for (int i = 0; i < 3; i++) begin
      ctrl_m = req[i];
      xfer(0, CA, ctrl_m, OK);
      repeat (3) @(posedge clk_i);
      `CHK(mode, pmgr_pkg::MODE_ACTIVE)
      pulse(1'b1);
      wait_mode(tgt[i]);
      `CHK(stall, 1'b1)
      check_clk();
      xfer(1, KA, crc_m, OK);
      pulse(1'b0);
      wait_mode(pmgr_pkg::MODE_ACTIVE);
      `CHK(stall, 1'b0)
      xfer(1, pmgr_pkg::STAT_ADDR, 8'h07, OK);
    end
    $display("mode test done");
    summarize();
  end
endmodule : pmgr_power_mode_manager_tb
